/* File: rtl/kcc_keypad_ctrl.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module kcc_keypad_ctrl
    import kcc_pkg::*;
#(
    parameter longint HOLD_CYCLES    = HOLD_CYC,
    parameter longint FAULT_CYCLES   = FAULT_CYC,
    parameter longint IDLE_CYCLES    = IDLE_CYC,
    parameter longint CONFIRM_CYCLES = CONFIRM_CYC,
    parameter longint SEC_CYCLES     = SEC_CYC
)(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        key_span,
    input  wire logic        key_zero,
    input  wire logic        key_esc,
    input  wire logic        key_ok,
    input  wire logic        dry_mode,
    input  wire logic        fault_hi_sel,
    input  wire logic [15:0] pressure,
    input  wire logic        pressure_valid,
    output logic             keypad_active,
    output logic [14:0]      loop_current,
    output logic [15:0]      zero_stored,
    output logic [15:0]      span_stored,
    output logic [2:0]       itime_stored,
    output logic             fault_hi_stored,
    output logic             store_strobe
);
    typedef enum logic [2:0] {
        KCC_LOCKED, KCC_BASIC, KCC_ADJ_ZERO, KCC_ADJ_SPAN, KCC_ITIME
    } kcc_state_e;

    kcc_state_e       state_reg;
    kcc_out_e         out_mode_reg;
    logic [3:0]       keys_prev_reg;
    logic [TMR_W-1:0] hold_reg;
    logic [TMR_W-1:0] idle_reg;
    logic [TMR_W-1:0] out_tmr_reg;
    logic             hold_done_reg;
    logic [15:0]      zero_pend_reg;
    logic [15:0]      span_pend_reg;
    logic [2:0]       itime_pend_reg;
    logic [14:0]      cur_pend_reg;
    logic [15:0]      avg_val;
    logic [3:0]       keys;
    logic [3:0]       press;
    logic             any_key;
    logic             hold_fire;
    logic             ok_evt;
    logic             fail_evt;

    assign keys    = {key_span, key_zero, key_esc, key_ok};
    assign press   = keys & ~keys_prev_reg;
    assign any_key = |keys;
    // a combination fires once per hold, when the counter reaches the limit
    assign hold_fire = !hold_done_reg && hold_reg == TMR_W'(HOLD_CYCLES - 1);

    // current code above 4 mA to pressure code: (i - 4mA) * full / 16mA
    function automatic logic [15:0] cur_to_val(input logic [14:0] cur);
        logic [31:0] prod;
        prod = 32'(cur - CUR_4MA) * 32'(NOM_MAX);
        cur_to_val = 16'(prod / 32'(CUR_SPAN16));
    endfunction

    // zero move keeps width, clamps end at nominal maximum
    function automatic logic [15:0] fit_span(input logic [15:0] z, input logic [15:0] s);
        fit_span = (17'(z) + 17'(s) > 17'(NOM_MAX)) ? NOM_MAX - z : s;
    endfunction

    kcc_averager #(
        .SEC_CYCLES  (SEC_CYCLES)
    ) u_avg (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .sample      (pressure),
        .sample_valid(pressure_valid),
        .itime_sel   (itime_stored),
        .avg_reg     (avg_val)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            keys_prev_reg <= 4'h0;
            hold_reg      <= '0;
            hold_done_reg <= 1'b0;
        end else begin
            keys_prev_reg <= keys;
            if (keys != keys_prev_reg) begin
                hold_reg      <= '0;
                hold_done_reg <= 1'b0;
            end else if (hold_fire) begin
                hold_done_reg <= 1'b1;
            end else if (!hold_done_reg && $countones(keys) >= 2) begin
                hold_reg <= hold_reg + TMR_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            idle_reg <= '0;
        end else if (state_reg == KCC_LOCKED || any_key) begin
            idle_reg <= '0;
        end else begin
            idle_reg <= idle_reg + TMR_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // single-key actions need press with no other key held
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg       <= KCC_LOCKED;
            zero_stored     <= ZERO_DEF;
            span_stored     <= SPAN_DEF;
            itime_stored    <= ITIME_DEF;
            fault_hi_stored <= FAULT_HI_DEF;
            zero_pend_reg   <= ZERO_DEF;
            span_pend_reg   <= SPAN_DEF;
            itime_pend_reg  <= ITIME_DEF;
            cur_pend_reg    <= CUR_4MA;
            store_strobe    <= 1'b0;
            ok_evt          <= 1'b0;
            fail_evt        <= 1'b0;
        end else begin
            store_strobe <= 1'b0;
            ok_evt       <= 1'b0;
            fail_evt     <= 1'b0;
            if (state_reg != KCC_LOCKED && idle_reg == TMR_W'(IDLE_CYCLES - 1)) begin
                state_reg      <= KCC_LOCKED;
                zero_pend_reg  <= zero_stored;
                span_pend_reg  <= span_stored;
                itime_pend_reg <= itime_stored;
            end else if (hold_fire && keys == 4'b0111 && state_reg != KCC_LOCKED) begin
                zero_stored     <= ZERO_DEF;
                span_stored     <= SPAN_DEF;
                itime_stored    <= ITIME_DEF;
                fault_hi_stored <= FAULT_HI_DEF;
                zero_pend_reg   <= ZERO_DEF;
                span_pend_reg   <= SPAN_DEF;
                itime_pend_reg  <= ITIME_DEF;
                store_strobe    <= 1'b1;
                ok_evt          <= 1'b1;
                state_reg       <= KCC_BASIC;
            end else if (hold_fire && keys == 4'b0011) begin
                state_reg <= KCC_BASIC;
                ok_evt    <= 1'b1;
            end else if (hold_fire && keys == 4'b1100 && state_reg != KCC_LOCKED) begin
                state_reg      <= KCC_ITIME;
                itime_pend_reg <= itime_stored;
                ok_evt         <= 1'b1;
            end else begin
                unique case (state_reg)
                    KCC_LOCKED: begin
                    end
                    KCC_BASIC: begin
                        if (press == 4'b0100 && keys == 4'b0100) begin
                            if (dry_mode) begin
                                state_reg    <= KCC_ADJ_ZERO;
                                cur_pend_reg <= CUR_4MA;
                            end else if (avg_val > NOM_MAX || avg_val < NOM_MIN) begin
                                fail_evt <= 1'b1;
                            end else begin
                                zero_pend_reg <= avg_val;
                                span_pend_reg <= fit_span(avg_val, span_stored);
                                ok_evt        <= 1'b1;
                            end
                        end else if (press == 4'b1000 && keys == 4'b1000) begin
                            if (dry_mode) begin
                                state_reg    <= KCC_ADJ_SPAN;
                                cur_pend_reg <= CUR_20MA;
                            end else if (avg_val <= zero_pend_reg) begin
                                fail_evt <= 1'b1;
                            end else begin
                                span_pend_reg <= avg_val - zero_pend_reg;
                                ok_evt        <= 1'b1;
                            end
                        end else if (press == 4'b0001 && keys == 4'b0001) begin
                            zero_stored  <= zero_pend_reg;
                            span_stored  <= span_pend_reg;
                            store_strobe <= 1'b1;
                            ok_evt       <= 1'b1;
                        end else if (press == 4'b0010 && keys == 4'b0010) begin
                            zero_pend_reg <= zero_stored;
                            span_pend_reg <= span_stored;
                            state_reg     <= KCC_LOCKED;
                        end
                    end
                    KCC_ADJ_ZERO, KCC_ADJ_SPAN: begin
                        if (press == 4'b1000 && keys == 4'b1000 && cur_pend_reg < CUR_20MA) begin
                            cur_pend_reg <= cur_pend_reg + 15'h000A;
                        end else if (press == 4'b0100 && keys == 4'b0100
                                     && cur_pend_reg > CUR_4MA) begin
                            cur_pend_reg <= cur_pend_reg - 15'h000A;
                        end else if (press == 4'b0001 && keys == 4'b0001) begin
                            if (state_reg == KCC_ADJ_ZERO) begin
                                zero_pend_reg <= cur_to_val(cur_pend_reg);
                                span_pend_reg <= fit_span(cur_to_val(cur_pend_reg),
                                                          span_pend_reg);
                            end else begin
                                span_pend_reg <= fit_span(zero_pend_reg,
                                                          cur_to_val(cur_pend_reg));
                            end
                            ok_evt    <= 1'b1;
                            state_reg <= KCC_BASIC;
                        end else if (press == 4'b0010 && keys == 4'b0010) begin
                            state_reg <= KCC_BASIC;
                        end
                    end
                    KCC_ITIME: begin
                        if (press == 4'b1000 && keys == 4'b1000) begin
                            itime_pend_reg <= (itime_pend_reg == 3'(NUM_ITIME - 1)) ?
                                              itime_pend_reg : itime_pend_reg + 3'h1;
                        end else if (press == 4'b0100 && keys == 4'b0100) begin
                            itime_pend_reg <= (itime_pend_reg == 3'h0) ?
                                              3'h0 : itime_pend_reg - 3'h1;
                        end else if (press == 4'b0001 && keys == 4'b0001) begin
                            itime_stored <= itime_pend_reg;
                            store_strobe <= 1'b1;
                            ok_evt       <= 1'b1;
                            state_reg    <= KCC_BASIC;
                        end else if (press == 4'b0010 && keys == 4'b0010) begin
                            itime_pend_reg <= itime_stored;
                            state_reg      <= KCC_BASIC;
                        end
                    end
                endcase
            end
            // fault level is taken from its pin whenever the keypad is live
            if (state_reg != KCC_LOCKED)
                fault_hi_stored <= fault_hi_sel;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            keypad_active <= 1'b0;
        end else begin
            keypad_active <= state_reg != KCC_LOCKED;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fault wins over a confirmation pulse already running
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_mode_reg <= KCC_OUT_MEAS;
            out_tmr_reg  <= '0;
        end else if (fail_evt) begin
            out_mode_reg <= KCC_OUT_FAULT;
            out_tmr_reg  <= TMR_W'(FAULT_CYCLES - 1);
        end else if (ok_evt && out_mode_reg != KCC_OUT_FAULT) begin
            out_mode_reg <= KCC_OUT_CONF;
            out_tmr_reg  <= TMR_W'(CONFIRM_CYCLES - 1);
        end else if (out_mode_reg != KCC_OUT_MEAS) begin
            if (out_tmr_reg == '0)
                out_mode_reg <= KCC_OUT_MEAS;
            else
                out_tmr_reg <= out_tmr_reg - TMR_W'(1);
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            loop_current <= CUR_4MA;
        end else begin
            unique case (out_mode_reg)
                KCC_OUT_CONF:  loop_current <= CUR_20MA;
                KCC_OUT_FAULT: loop_current <= fault_hi_stored ? CUR_21MA : CUR_3M6;
                KCC_OUT_MEAS: begin
                    if (state_reg == KCC_ADJ_ZERO || state_reg == KCC_ADJ_SPAN)
                        loop_current <= cur_pend_reg;
                    else if (avg_val <= zero_stored || span_stored == 16'h0)
                        loop_current <= CUR_4MA;
                    else if (avg_val - zero_stored >= span_stored)
                        loop_current <= CUR_20MA;
                    else
                        loop_current <= CUR_4MA + 15'((32'(avg_val - zero_stored)
                                        * 32'(CUR_SPAN16)) / 32'(span_stored));
                end
                default: loop_current <= CUR_4MA;
            endcase
        end
    end
endmodule

/* File: include/kcc_pkg.sv */
package kcc_pkg;
    // pressure codes: 0 = range start, full = nominal end; current codes use their own scale
    localparam int          VAL_W        = 16;
    localparam logic [15:0] NOM_MAX      = 16'hFFFF;
    localparam logic [15:0] NOM_MIN      = 16'h0000;
    // loop current codes in units of 1/1000 mA
    localparam int          CUR_W        = 15;
    localparam logic [14:0] CUR_4MA      = 15'h0FA0;
    localparam logic [14:0] CUR_20MA     = 15'h4E20;
    localparam logic [14:0] CUR_21MA     = 15'h5208;
    localparam logic [14:0] CUR_3M6      = 15'h0E10;
    localparam logic [14:0] CUR_SPAN16   = 15'h3E80;
    localparam longint      CLK_HZ       = 40000000;
    localparam longint      HOLD_MS      = 2000;
    localparam longint      FAULT_MS     = 5000;
    localparam longint      IDLE_MS      = 600000;
    localparam longint      CONFIRM_MS   = 200;
    localparam longint      HOLD_CYC     = CLK_HZ * HOLD_MS / 1000;
    localparam longint      FAULT_CYC    = CLK_HZ * FAULT_MS / 1000;
    localparam longint      IDLE_CYC     = CLK_HZ * IDLE_MS / 1000;
    localparam longint      CONFIRM_CYC  = CLK_HZ * CONFIRM_MS / 1000;
    localparam longint      SEC_CYC      = CLK_HZ;
    localparam int          TMR_W        = 35;
    // integration time choices, in seconds
    localparam int          NUM_ITIME    = 5;
    localparam logic [2:0]  ITIME_DEF    = 3'h0;
    localparam logic [15:0] ADJ_STEP     = 16'h0010;
    localparam logic [15:0] ZERO_DEF     = 16'h0000;
    localparam logic [15:0] SPAN_DEF     = 16'hFFFF;
    localparam logic        FAULT_HI_DEF = 1'b1;
    localparam int          ACC_W        = 48;

    typedef enum logic [1:0] {KCC_OUT_MEAS, KCC_OUT_CONF, KCC_OUT_FAULT} kcc_out_e;

    function automatic logic [5:0] kcc_itime_sec(input logic [2:0] idx);
        case (idx)
            3'h0:    kcc_itime_sec = 6'h00;
            3'h1:    kcc_itime_sec = 6'h01;
            3'h2:    kcc_itime_sec = 6'h05;
            3'h3:    kcc_itime_sec = 6'h14;
            default: kcc_itime_sec = 6'h28;
        endcase
    endfunction
endpackage

/* File: rtl/kcc_averager.sv */
`timescale 1ns/1ps
module kcc_averager
    import kcc_pkg::*;
#(
    parameter longint SEC_CYCLES = SEC_CYC
)(
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire logic [15:0]      sample,
    input  wire logic             sample_valid,
    input  wire logic [2:0]       itime_sel,
    output logic      [15:0]      avg_reg
);
    // block average: sums samples over the window, publishes sum / count
    logic [ACC_W-1:0] acc_reg;
    logic [31:0]      cnt_reg;
    logic [TMR_W-1:0] tick_reg;
    logic [5:0]       sec_reg;
    logic             win_end;

    assign win_end = (kcc_itime_sec(itime_sel) == 6'h00) ||
                     (tick_reg == TMR_W'(SEC_CYCLES - 1) && sec_reg + 6'h01 >= kcc_itime_sec(itime_sel));

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_reg <= '0;
            sec_reg  <= '0;
        end else if (kcc_itime_sec(itime_sel) == 6'h00 || win_end) begin
            tick_reg <= '0;
            sec_reg  <= '0;
        end else if (tick_reg == TMR_W'(SEC_CYCLES - 1)) begin
            tick_reg <= '0;
            sec_reg  <= sec_reg + 6'h01;
        end else begin
            tick_reg <= tick_reg + TMR_W'(1);
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_reg <= '0;
            cnt_reg <= '0;
            avg_reg <= '0;
        end else if (win_end) begin
            if (kcc_itime_sec(itime_sel) == 6'h00) begin
                if (sample_valid)
                    avg_reg <= sample;
            end else if (cnt_reg != 32'h0) begin
                avg_reg <= 16'(acc_reg / ACC_W'(cnt_reg));
            end
            acc_reg <= '0;
            cnt_reg <= '0;
        end else if (sample_valid) begin
            acc_reg <= acc_reg + ACC_W'(sample);
            cnt_reg <= cnt_reg + 32'h1;
        end
    end
endmodule

/* File: testbench/kcc_keypad_checker.sv */
`timescale 1ns/1ps
module kcc_keypad_checker
    import kcc_pkg::*;
#(
    parameter longint CONFIRM_CYCLES = CONFIRM_CYC,
    parameter longint FAULT_CYCLES   = FAULT_CYC,
    parameter longint IDLE_CYCLES    = IDLE_CYC
)(
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        key_span,
    input wire logic        key_zero,
    input wire logic        key_esc,
    input wire logic        key_ok,
    input wire logic        dry_mode,
    input wire logic        fault_hi_sel,
    input wire logic [15:0] pressure,
    input wire logic        pressure_valid,
    input wire logic        keypad_active,
    input wire logic [14:0] loop_current,
    input wire logic [15:0] zero_stored,
    input wire logic [15:0] span_stored,
    input wire logic [2:0]  itime_stored,
    input wire logic        fault_hi_stored,
    input wire logic        store_strobe
);
    int   conf_cnt;
    int   flt_cnt;
    int   idle_cnt;
    wire  is_conf = loop_current == CUR_20MA;
    wire  is_flt  = loop_current == CUR_21MA || loop_current == CUR_3M6;
    wire  no_key  = !(key_span | key_zero | key_esc | key_ok);
    // run lengths, too long for a repetition operator
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            conf_cnt <= 0;
            flt_cnt  <= 0;
            idle_cnt <= 0;
        end else begin
            conf_cnt <= is_conf ? conf_cnt + 1 : 0;
            flt_cnt  <= is_flt ? flt_cnt + 1 : 0;
            idle_cnt <= (keypad_active && no_key) ? idle_cnt + 1 : 0;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    strobe_one_a: assert property (store_strobe |=> !store_strobe)
        else $error("commit strobe longer than one cycle");
    strobe_conf_a: assert property (store_strobe |-> ##2 is_conf)
        else $error("no confirmation after commit");
    conf_rise_a: assert property ($rose(is_conf) |-> is_conf[*8])
        else $error("confirmation cut short");
    conf_bound_a: assert property (conf_cnt <= CONFIRM_CYCLES)
        else $error("confirmation too long");
    flt_bound_a: assert property (flt_cnt <= FAULT_CYCLES)
        else $error("fault current too long");
    flt_quiet_a: assert property (is_flt |-> !store_strobe && $stable(zero_stored))
        else $error("value stored during fault");
    flt_level_a: assert property (is_flt |-> is_conf == 1'b0 &&
        loop_current == (fault_hi_stored ? CUR_21MA : CUR_3M6))
        else $error("fault current not the selected level");
    hold_store_a: assert property (!store_strobe |-> $stable(zero_stored) &&
        $stable(span_stored) && $stable(itime_stored))
        else $error("stored value changed without commit");
    end_range_a: assert property ({1'b0, zero_stored} + {1'b0, span_stored} <= 17'h0FFFF)
        else $error("span end beyond nominal maximum");
    itime_max_a: assert property (itime_stored <= 3'h4)
        else $error("integration index out of range");
    unlock_a: assert property ($rose(keypad_active) |-> $past(key_esc & key_ok, 3))
        else $error("keypad unlocked without esc and ok");
    idle_lock_a: assert property (idle_cnt <= IDLE_CYCLES + 8)
        else $error("keypad stayed active while idle");
endmodule
bind kcc_keypad_ctrl kcc_keypad_checker #(.CONFIRM_CYCLES(CONFIRM_CYCLES),
    .FAULT_CYCLES(FAULT_CYCLES), .IDLE_CYCLES(IDLE_CYCLES)) u_chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .key_span(key_span), .key_zero(key_zero),
    .key_esc(key_esc), .key_ok(key_ok), .dry_mode(dry_mode), .fault_hi_sel(fault_hi_sel),
    .pressure(pressure), .pressure_valid(pressure_valid), .keypad_active(keypad_active),
    .loop_current(loop_current), .zero_stored(zero_stored), .span_stored(span_stored),
    .itime_stored(itime_stored), .fault_hi_stored(fault_hi_stored), .store_strobe(store_strobe));

/* File: testbench/kcc_operator.sv */
`timescale 1ns/1ps
module kcc_operator
    import kcc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic [14:0] loop_current,
    input  wire logic        store_strobe,
    output logic             key_span,
    output logic             key_zero,
    output logic             key_esc,
    output logic             key_ok,
    output logic [15:0]      pressure,
    output logic             pressure_valid
);
    logic [15:0] press_code = 16'h4000;
    logic [1:0]  tick       = 2'h0;
    logic [14:0] fault_val  = 15'h0000;
    int          run_c      = 0;
    int          run_f      = 0;
    int          conf_len   = 0;
    int          fault_len  = 0;
    int          strobes    = 0;
    initial begin
        {key_span, key_zero, key_esc, key_ok} = 4'h0;
        pressure       = 16'h4000;
        pressure_valid = 1'b0;
    end
    // sensor feed, one sample every fourth cycle
    always @(posedge core_clk) begin
        tick           <= tick + 2'h1;
        pressure_valid <= tick == 2'h3;
        if (tick == 2'h3) pressure <= press_code;
    end
    // meter: length of the last excursion and last fault
    always @(posedge core_clk) begin
        if (loop_current == CUR_20MA) run_c <= run_c + 1;
        else begin
            if (run_c != 0) conf_len <= run_c;
            run_c <= 0;
        end
        if (loop_current == CUR_21MA || loop_current == CUR_3M6) begin
            run_f     <= run_f + 1;
            fault_val <= loop_current;
        end else begin
            if (run_f != 0) fault_len <= run_f;
            run_f <= 0;
        end
        if (store_strobe) strobes <= strobes + 1;
    end
    // key set order span zero esc ok; gap after release so each press is a fresh edge
    task automatic press(input logic [3:0] k, input int n);
        {key_span, key_zero, key_esc, key_ok} <= k;
        repeat (n) @(posedge core_clk);
        {key_span, key_zero, key_esc, key_ok} <= 4'h0;
        repeat (3) @(posedge core_clk);
    endtask
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
module testbench
    import kcc_pkg::*;
;
    localparam int HOLD = 20;
    localparam int FLT  = 50;
    localparam int IDLE = 200;
    localparam int CONF = 10;
    localparam logic [3:0] K_SPAN = 4'h8;
    localparam logic [3:0] K_ZERO = 4'h4;
    localparam logic [3:0] K_OK   = 4'h1;
    logic        core_clk;
    logic        sys_rst;
    logic        dry_mode;
    logic        fault_hi_sel;
    logic        key_span, key_zero, key_esc, key_ok, pressure_valid;
    logic [15:0] pressure, zero_stored, span_stored;
    logic        keypad_active, fault_hi_stored, store_strobe;
    logic [14:0] loop_current;
    logic [2:0]  itime_stored;
    int          error_cnt = 0;
    int          compares  = 0;
    kcc_keypad_ctrl #(.HOLD_CYCLES(HOLD), .FAULT_CYCLES(FLT), .IDLE_CYCLES(IDLE),
        .CONFIRM_CYCLES(CONF), .SEC_CYCLES(10)) u_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .key_span(key_span), .key_zero(key_zero),
        .key_esc(key_esc), .key_ok(key_ok), .dry_mode(dry_mode), .fault_hi_sel(fault_hi_sel),
        .pressure(pressure), .pressure_valid(pressure_valid), .keypad_active(keypad_active),
        .loop_current(loop_current), .zero_stored(zero_stored), .span_stored(span_stored),
        .itime_stored(itime_stored), .fault_hi_stored(fault_hi_stored),
        .store_strobe(store_strobe));
    kcc_operator u_op (.core_clk(core_clk), .loop_current(loop_current),
        .store_strobe(store_strobe), .key_span(key_span), .key_zero(key_zero),
        .key_esc(key_esc), .key_ok(key_ok), .pressure(pressure),
        .pressure_valid(pressure_valid));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic vals(input logic [15:0] z, input logic [15:0] s);
        chk("zero", zero_stored, z);
        chk("span", span_stored, s);
    endtask
    task automatic unlock;
        u_op.press(4'h3, HOLD + CONF + 4);
        chk("unlocked", keypad_active, 1'b1);
    endtask
    // back to quarter scale so the live output never sits at 20 mA
    task automatic wet(input logic [3:0] k, input logic [15:0] p);
        u_op.press_code = p;
        cyc(10);
        u_op.press(k, 2);
        u_op.press_code = 16'h4000;
        cyc(10);
    endtask
    task automatic commit;
        int s;
        s = u_op.strobes;
        u_op.press(K_OK, 2);
        cyc(CONF + 4);
        chk("strobes", u_op.strobes - s, 1);
        chk("confirm len", u_op.conf_len, CONF);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_locked;
        chk("locked", keypad_active, 1'b0);
        vals(16'h0000, 16'hFFFF);
        chk("itime", itime_stored, 3'h0);
        chk("fault hi", fault_hi_stored, 1'b1);
        wet(K_ZERO, 16'h1000);
        u_op.press(K_OK, 2);
        cyc(5);
        chk("no strobe", u_op.strobes, 0);
        vals(16'h0000, 16'hFFFF);
    endtask
    task automatic t_wet_cal;
        unlock();
        wet(K_ZERO, 16'h1000);
        commit();
        vals(16'h1000, 16'hEFFF);
        wet(K_SPAN, 16'h9000);
        commit();
        vals(16'h1000, 16'h8000);
        wet(K_ZERO, 16'h2000);
        commit();
        vals(16'h2000, 16'h8000);
    endtask
    task automatic t_fault;
        for (int i = 0; i < 2; i++) begin
            fault_hi_sel <= (i == 0);
            cyc(2);
            wet(K_SPAN, 16'h1000);
            cyc(FLT);
            chk("fault len", u_op.fault_len, FLT);
            chk("fault level", u_op.fault_val, (i == 0) ? CUR_21MA : CUR_3M6);
            commit();
            vals(16'h2000, 16'h8000);
        end
        fault_hi_sel <= 1'b1;
    endtask
    task automatic t_itime;
        u_op.press(K_SPAN | K_ZERO, HOLD + 4);
        repeat (4) u_op.press(K_SPAN, 2);
        u_op.press(K_ZERO, 2);
        commit();
        chk("itime", itime_stored, 3'h3);
    endtask
    task automatic t_idle;
        wet(K_ZERO, 16'h3000);
        cyc(IDLE + 10);
        chk("idle lock", keypad_active, 1'b0);
        unlock();
        commit();
        vals(16'h2000, 16'h8000);
    endtask
    task automatic t_dry;
        dry_mode <= 1'b1;
        u_op.press(K_ZERO, 2);
        u_op.press(K_SPAN, 2);
        u_op.press(K_OK, CONF + 2);
        commit();
        vals(16'h0028, 16'h8000);
        u_op.press(K_ZERO, 2);
        u_op.press(K_SPAN, 2);
        u_op.press(4'h2, 2);
        u_op.press(4'h2, 2);
        chk("esc lock", keypad_active, 1'b0);
        vals(16'h0028, 16'h8000);
        dry_mode <= 1'b0;
    endtask
    task automatic t_defaults;
        int s;
        unlock();
        s = u_op.strobes;
        u_op.press(4'h7, HOLD + 4);
        cyc(CONF + 4);
        chk("default strobe", u_op.strobes - s, 1);
        vals(16'h0000, 16'hFFFF);
        chk("itime", itime_stored, 3'h0);
        chk("still active", keypad_active, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst      = 1'b1;
        dry_mode     = 1'b0;
        fault_hi_sel = 1'b1;
        cyc(16);
        sys_rst <= 1'b0;
        cyc(2);
        t_locked();
        t_wet_cal();
        t_fault();
        t_itime();
        t_idle();
        t_dry();
        t_defaults();
        close_out();
    end
    // under a thousand cycles expected; cut off well beyond that
    initial begin
        cyc(20000);
        error_cnt++;
        $display("BAD watchdog expired");
        close_out();
    end
endmodule
